// ===== rtl/lsr_pkg.sv
/*
  Shared constants, types and helper functions for the LIN status and
  memory readback link: frame identifiers, command codes, field layout of
  the status snapshot, controller register offsets.
  Assumes the link is modelled at byte level, one byte per clock.
*/
package lsr_pkg;
  // ==========================================================
  // Frame identifiers and command bytes
  // ==========================================================
  localparam logic [7:0] ID_PREP8    = 8'h3c;
  localparam logic [7:0] ID_READ     = 8'h7d;
  localparam logic [7:0] APP_MARK    = 8'h80;
  localparam logic [7:0] FILL_BYTE   = 8'hff;
  localparam logic       MARK_BIT    = 1'b1;
  localparam logic [6:0] CMD_FULL    = 7'h01;
  localparam logic [6:0] CMD_PROM    = 7'h02;
  localparam logic [3:0] FS1_PAD     = 4'hf;
  localparam logic       FS2_ONE     = 1'b1;
  localparam logic [3:0] LEN_PREP8   = 4'h8;
  localparam logic [3:0] LEN_PREP7   = 4'h2;
  localparam logic [3:0] LEN_RESP    = 4'h8;
  localparam logic [3:0] LEN_TX8     = 4'h9;
  localparam logic [3:0] LEN_TX7     = 4'h3;

  // ==========================================================
  // Controller registers (word index = byte offset / 4)
  // ==========================================================
  localparam logic [2:0] REG_CTRL    = 3'h0;
  localparam logic [2:0] REG_IRQ_ST  = 3'h1;
  localparam logic [2:0] REG_IRQ_MSK = 3'h2;
  localparam logic [2:0] REG_RESP0   = 3'h3;
  localparam logic [2:0] REG_RESP1   = 3'h4;
  localparam logic [2:0] REG_RESP2   = 3'h5;
  localparam logic [2:0] REG_RESP3   = 3'h6;
  localparam int         IRQ_DONE    = 0;
  localparam int         IRQ_ERR     = 1;
  localparam int         CTRL_SHORT  = 8;
  localparam int         CTRL_SKIP2  = 9;
  localparam int         CTRL_BUSY   = 31;

  typedef struct packed {
    logic [3:0]  run_current;
    logic [3:0]  hold_current;
    logic [3:0]  max_velocity;
    logic [3:0]  min_velocity;
    logic        accel_shape_select;
    logic [1:0]  step_resolution_select;
    logic        shaft_direction;
    logic [3:0]  acceleration;
    logic        supply_reset_flag;
    logic        lost_step_flag;
    logic        electrical_defect_flag;
    logic        undervoltage_flag;
    logic        thermal_shutdown_flag;
    logic        thermal_warning_flag;
    logic [1:0]  temperature_info;
    logic [2:0]  motion_state;
    logic        external_switch_state;
    logic        coil_x_overcurrent_flag;
    logic        coil_y_overcurrent_flag;
    logic        stall_flag;
    logic        charge_pump_fail_flag;
    logic        lin_timeout_error;
    logic        lin_data_error;
    logic        lin_header_error;
    logic        lin_bit_error;
    logic [3:0]  absolute_stall_threshold;
    logic [3:0]  delta_stall_threshold;
    logic [15:0] actual_position;
    logic [15:0] target_position;
    logic [10:0] secure_position;
    logic [2:0]  stall_enable_field;
    logic        full_duty_flag;
    logic        absolute_stall_flag;
    logic        delta_stall_low_flag;
    logic        delta_stall_high_flag;
    logic [2:0]  minimum_sample_count;
    logic        full_duty_stall_enable;
    logic        pwm_jitter_enable;
  } lsr_status_type;

  // Identifier with the two protected bits on top
  function automatic logic [7:0] id_with_parity(input logic [5:0] id);
    return {~(id[1] ^ id[3] ^ id[4] ^ id[5]),
            id[0] ^ id[1] ^ id[2] ^ id[4], id};
  endfunction : id_with_parity

  // Classic sum with end-around carry
  function automatic logic [7:0] csum_add(input logic [7:0] acc,
                                          input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, acc} + {1'b0, b};
    return s[7:0] + {7'h00, s[8]};
  endfunction : csum_add
endpackage : lsr_pkg

// ===== rtl/lsr_link_if.sv
/*
  Byte-level link between the bus master end and the slave device end.
  Assumes both ends run on the same clock; every strobe lasts one cycle.
*/
`timescale 1ns/1ps
interface lsr_link_if;
  logic       hdr_vld;
  logic       byte_vld;
  logic [7:0] m_byte;
  logic       rsp_vld;
  logic [7:0] rsp_byte;

  modport master (output hdr_vld, output byte_vld, output m_byte,
                  input rsp_vld, input rsp_byte);
  modport device (input hdr_vld, input byte_vld, input m_byte,
                  output rsp_vld, output rsp_byte);
endinterface : lsr_link_if

// ===== rtl/lsr_device.sv
/*
  Slave end: decodes preparing frames for the full status and memory
  readback commands and answers the following reading frames.
  Assumes the status snapshot and memory bytes are stable inputs and the
  master keeps its half of the frame formats.
*/
// Function
// - Master: type 8 prepare then type 6 read
// - Type 8 prepare: 0x3C, marker, cmd, address, fill
// - First status response carries currents, velocities, flags
// - Second response: actual, target, secure low byte
// - Byte 8: stall flags, samples, duty enable, jitter
// - Identifier parity bits from lower six bits
// - Memory read returns the prepared segment
// - Memory answer on indirect identifier 0x3D
// - Master: type 7 prepare then type 6 read
// - Type 7 prepare: parity id, cmd, address, checksum
// - Memory bytes 0x00 to 0x07 in data 1-8
// - Full status gives two responses, second optional
// - Serving full status clears the latched fault flags
`timescale 1ns/1ps
module lsr_device (
  input  wire logic                  sys_clk,
  input  wire logic                  srst,
  lsr_link_if.device                 lnk,
  input  wire logic [6:0]            node_addr,
  input  wire logic [4:0]            dyn_id,
  input  wire lsr_pkg::lsr_status_type status,
  input  wire logic [63:0]           prom_data,
  output logic                       flag_clear
);
  // ==========================================================
  // Types and state
  // ==========================================================
  typedef enum logic [1:0] {D_IDLE, D_RX, D_TX} lsr_dev_state_type;
  typedef enum logic [1:0] {P_NONE, P_FS1, P_FS2, P_PROM} lsr_pend_type;

  lsr_dev_state_type state_r, state_nxt;
  lsr_pend_type      pend_r, pend_nxt;
  logic [3:0]        cnt_r, cnt_nxt;
  logic [3:0]        len_r, len_nxt;
  logic              short_r, short_nxt;
  logic [7:0]        acc_r, acc_nxt;
  logic [63:0]       sh_r, sh_nxt;
  logic [7:0]        buf_r [0:7];
  logic [7:0]        buf_nxt [0:7];
  logic              rv_r, rv_nxt;
  logic [7:0]        rb_r, rb_nxt;
  logic              clr_r, clr_nxt;
  logic [7:0]        cmd_b;
  logic [7:0]        adr_b;
  logic              prep_ok;

  // ==========================================================
  // Response image, first data byte in the top bits
  // ==========================================================
  function automatic logic [63:0] build_resp(
    input lsr_pend_type            p,
    input lsr_pkg::lsr_status_type s,
    input logic [63:0]             prom,
    input logic [6:0]              ad);
    logic [63:0] r;
    r = prom;
    if (p == P_FS1) begin
      r = {lsr_pkg::MARK_BIT, ad,
           s.run_current, s.hold_current,
           s.max_velocity, s.min_velocity,
           s.accel_shape_select, s.step_resolution_select,
           s.shaft_direction, s.acceleration,
           s.supply_reset_flag, s.lost_step_flag,
           s.electrical_defect_flag, s.undervoltage_flag,
           s.thermal_shutdown_flag, s.thermal_warning_flag,
           s.temperature_info,
           s.motion_state, s.external_switch_state,
           s.coil_x_overcurrent_flag, s.coil_y_overcurrent_flag,
           s.stall_flag, s.charge_pump_fail_flag,
           lsr_pkg::FS1_PAD, s.lin_timeout_error, s.lin_data_error,
           s.lin_header_error, s.lin_bit_error,
           s.absolute_stall_threshold, s.delta_stall_threshold};
    end else if (p == P_FS2) begin
      r = {lsr_pkg::MARK_BIT, ad,
           s.actual_position, s.target_position,
           s.secure_position[7:0],
           s.stall_enable_field, lsr_pkg::FS2_ONE,
           s.full_duty_flag, s.secure_position[10:8],
           s.absolute_stall_flag, s.delta_stall_low_flag,
           s.delta_stall_high_flag, s.minimum_sample_count,
           s.full_duty_stall_enable, s.pwm_jitter_enable};
    end
    return r;
  endfunction : build_resp

  // ==========================================================
  // Preparing frame decode
  // ==========================================================
  always_comb begin
    cmd_b   = short_r ? buf_r[0] : buf_r[1];
    adr_b   = short_r ? buf_r[1] : buf_r[2];
    prep_ok = (adr_b == {lsr_pkg::MARK_BIT, node_addr})
            && cmd_b[7] == lsr_pkg::MARK_BIT;
    if (!short_r) begin
      prep_ok = prep_ok && buf_r[0] == lsr_pkg::APP_MARK
              && buf_r[3] == lsr_pkg::FILL_BYTE
              && buf_r[4] == lsr_pkg::FILL_BYTE
              && buf_r[5] == lsr_pkg::FILL_BYTE
              && buf_r[6] == lsr_pkg::FILL_BYTE
              && buf_r[7] == lsr_pkg::FILL_BYTE;
    end
  end

  // ==========================================================
  // Frame engine
  // ==========================================================
  always_comb begin
    state_nxt = state_r;
    pend_nxt  = pend_r;
    cnt_nxt   = cnt_r;
    len_nxt   = len_r;
    short_nxt = short_r;
    acc_nxt   = acc_r;
    sh_nxt    = sh_r;
    buf_nxt   = buf_r;
    rv_nxt    = 1'b0;
    rb_nxt    = rb_r;
    clr_nxt   = 1'b0;
    if (lnk.hdr_vld) begin
      // A new header always aborts the frame in progress
      cnt_nxt   = '0;
      acc_nxt   = '0;
      state_nxt = D_IDLE;
      if (lnk.m_byte == lsr_pkg::ID_PREP8) begin
        state_nxt = D_RX;
        len_nxt   = lsr_pkg::LEN_PREP8;
        short_nxt = 1'b0;
      end else if (lnk.m_byte ==
                   lsr_pkg::id_with_parity({1'b0, dyn_id})) begin
        state_nxt = D_RX;
        len_nxt   = lsr_pkg::LEN_PREP7;
        short_nxt = 1'b1;
      end else if (lnk.m_byte == lsr_pkg::ID_READ
                   && pend_r != P_NONE) begin
        state_nxt = D_TX;
        sh_nxt    = build_resp(pend_r, status, prom_data, node_addr);
        clr_nxt   = (pend_r == P_FS1);
        pend_nxt  = (pend_r == P_FS1) ? P_FS2 : P_NONE;
      end
    end else begin
      unique case (state_r)
        D_IDLE: begin
        end
        D_RX: begin
          if (lnk.byte_vld) begin
            if (cnt_r == len_r) begin
              state_nxt = D_IDLE;
              if (lnk.m_byte == ~acc_r && prep_ok) begin
                if (cmd_b[6:0] == lsr_pkg::CMD_FULL) begin
                  pend_nxt = P_FS1;
                end else if (cmd_b[6:0] == lsr_pkg::CMD_PROM) begin
                  pend_nxt = P_PROM;
                end
              end
            end else begin
              buf_nxt[cnt_r[2:0]] = lnk.m_byte;
              acc_nxt = lsr_pkg::csum_add(acc_r, lnk.m_byte);
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        D_TX: begin
          rv_nxt = 1'b1;
          if (cnt_r == lsr_pkg::LEN_RESP) begin
            rb_nxt    = ~acc_r;
            state_nxt = D_IDLE;
          end else begin
            rb_nxt  = sh_r[63:56];
            acc_nxt = lsr_pkg::csum_add(acc_r, sh_r[63:56]);
            sh_nxt  = {sh_r[55:0], 8'h00};
            cnt_nxt = cnt_r + 4'h1;
          end
        end
        default: begin
          state_nxt = D_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r <= D_IDLE;
      pend_r  <= P_NONE;
      cnt_r   <= '0;
      len_r   <= '0;
      short_r <= 1'b0;
      acc_r   <= '0;
      sh_r    <= '0;
      for (int i = 0; i < 8; i++) begin
        buf_r[i] <= '0;
      end
      rv_r    <= 1'b0;
      rb_r    <= '0;
      clr_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pend_r  <= pend_nxt;
      cnt_r   <= cnt_nxt;
      len_r   <= len_nxt;
      short_r <= short_nxt;
      acc_r   <= acc_nxt;
      sh_r    <= sh_nxt;
      buf_r   <= buf_nxt;
      rv_r    <= rv_nxt;
      rb_r    <= rb_nxt;
      clr_r   <= clr_nxt;
    end
  end

  assign lnk.rsp_vld  = rv_r;
  assign lnk.rsp_byte = rb_r;
  assign flag_clear   = clr_r;
endmodule : lsr_device

// ===== rtl/lsr_master.sv
/*
  Master end: an Avalon-MM slave register set that runs one full status or
  memory readback sequence per command and interrupts on completion.
  Assumes the device answers a reading frame within TMO_CYC cycles.
*/
// Design decisions made here: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
module lsr_master #(
  parameter int TMO_CYC = 64
) (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  lsr_link_if.master       lnk
);
  // ==========================================================
  // State
  // ==========================================================
  typedef enum logic [1:0] {M_IDLE, M_PREP, M_RHDR, M_RECV}
    lsr_mst_state_type;

  lsr_mst_state_type state_r, state_nxt;
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [1:0]  ist_r, ist_nxt;
  logic [1:0]  msk_r, msk_nxt;
  logic [63:0] resp_r [0:1];
  logic [63:0] resp_nxt [0:1];
  logic [79:0] tx_r, tx_nxt;
  logic [3:0]  cnt_r, cnt_nxt;
  logic [3:0]  last_r, last_nxt;
  logic [7:0]  acc_r, acc_nxt;
  logic [63:0] rx_r, rx_nxt;
  logic        ph_r, ph_nxt;
  logic [7:0]  tmo_r, tmo_nxt;
  logic        ack_r, ack_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic [1:0]  set_ev;
  logic [7:0]  cmd_b, adr_b, hdr7, ck7, ck8;

  // ==========================================================
  // Sequencer and registers
  // ==========================================================
  always_comb begin
    state_nxt = state_r;
    ctrl_nxt  = ctrl_r;
    msk_nxt   = msk_r;
    resp_nxt  = resp_r;
    tx_nxt    = tx_r;
    cnt_nxt   = cnt_r;
    last_nxt  = last_r;
    acc_nxt   = acc_r;
    rx_nxt    = rx_r;
    ph_nxt    = ph_r;
    tmo_nxt   = tmo_r;
    set_ev    = 2'b00;
    cmd_b     = {lsr_pkg::MARK_BIT, avs_writedata[6:0]};
    adr_b     = {lsr_pkg::MARK_BIT, avs_writedata[22:16]};
    hdr7      = lsr_pkg::id_with_parity({1'b0, avs_writedata[28:24]});
    ck7       = ~lsr_pkg::csum_add(cmd_b, adr_b);
    ck8       = ~lsr_pkg::csum_add(lsr_pkg::csum_add(
                  lsr_pkg::csum_add(lsr_pkg::csum_add(lsr_pkg::csum_add(
                  lsr_pkg::csum_add(lsr_pkg::csum_add(lsr_pkg::APP_MARK,
                  cmd_b), adr_b), lsr_pkg::FILL_BYTE), lsr_pkg::FILL_BYTE),
                  lsr_pkg::FILL_BYTE), lsr_pkg::FILL_BYTE),
                  lsr_pkg::FILL_BYTE);
    unique case (state_r)
      M_IDLE: begin
        if (avs_write && avs_address == lsr_pkg::REG_CTRL
            && (avs_writedata[6:0] == lsr_pkg::CMD_FULL
                || avs_writedata[6:0] == lsr_pkg::CMD_PROM)) begin
          ctrl_nxt  = avs_writedata;
          state_nxt = M_PREP;
          cnt_nxt   = '0;
          ph_nxt    = 1'b0;
          if (avs_writedata[lsr_pkg::CTRL_SHORT]) begin
            tx_nxt   = {hdr7, cmd_b, adr_b, ck7, 48'h0};
            last_nxt = lsr_pkg::LEN_TX7;
          end else begin
            tx_nxt   = {lsr_pkg::ID_PREP8, lsr_pkg::APP_MARK, cmd_b, adr_b,
                        {5{lsr_pkg::FILL_BYTE}}, ck8};
            last_nxt = lsr_pkg::LEN_TX8;
          end
        end
      end
      M_PREP: begin
        tx_nxt  = {tx_r[71:0], 8'h00};
        cnt_nxt = cnt_r + 4'h1;
        if (cnt_r == last_r) begin
          state_nxt     = M_RHDR;
          tx_nxt[79:72] = lsr_pkg::ID_READ;
        end
      end
      M_RHDR: begin
        state_nxt = M_RECV;
        cnt_nxt   = '0;
        acc_nxt   = '0;
        tmo_nxt   = '0;
      end
      M_RECV: begin
        tmo_nxt = tmo_r + 8'h01;
        if (lnk.rsp_vld) begin
          tmo_nxt = '0;
          if (cnt_r == lsr_pkg::LEN_RESP) begin
            if (lnk.rsp_byte != ~acc_r) begin
              set_ev[lsr_pkg::IRQ_ERR] = 1'b1;
              state_nxt = M_IDLE;
            end else begin
              resp_nxt[ph_r] = rx_r;
              if (ctrl_r[6:0] == lsr_pkg::CMD_FULL && !ph_r
                  && !ctrl_r[lsr_pkg::CTRL_SKIP2]) begin
                ph_nxt        = 1'b1;
                state_nxt     = M_RHDR;
                tx_nxt[79:72] = lsr_pkg::ID_READ;
              end else begin
                set_ev[lsr_pkg::IRQ_DONE] = 1'b1;
                state_nxt = M_IDLE;
              end
            end
          end else begin
            rx_nxt  = {rx_r[55:0], lnk.rsp_byte};
            acc_nxt = lsr_pkg::csum_add(acc_r, lnk.rsp_byte);
            cnt_nxt = cnt_r + 4'h1;
          end
        end else if (tmo_r == 8'(TMO_CYC - 1)) begin
          set_ev[lsr_pkg::IRQ_ERR] = 1'b1;
          state_nxt = M_IDLE;
        end
      end
    endcase
    // Status bits: a new event wins over a write-one clear
    ist_nxt = ist_r;
    if (avs_write && avs_address == lsr_pkg::REG_IRQ_ST) begin
      ist_nxt = ist_r & ~avs_writedata[1:0];
    end
    ist_nxt = ist_nxt | set_ev;
    if (avs_write && avs_address == lsr_pkg::REG_IRQ_MSK) begin
      msk_nxt = avs_writedata[1:0];
    end
    // Reads take one wait cycle, data registered
    ack_nxt = avs_read && !ack_r;
    rd_nxt  = rd_r;
    if (avs_read && !ack_r) begin
      unique case (avs_address)
        lsr_pkg::REG_CTRL:    rd_nxt = {state_r != M_IDLE, ctrl_r[30:0]};
        lsr_pkg::REG_IRQ_ST:  rd_nxt = {30'h0, ist_r};
        lsr_pkg::REG_IRQ_MSK: rd_nxt = {30'h0, msk_r};
        lsr_pkg::REG_RESP0:   rd_nxt = resp_r[0][63:32];
        lsr_pkg::REG_RESP1:   rd_nxt = resp_r[0][31:0];
        lsr_pkg::REG_RESP2:   rd_nxt = resp_r[1][63:32];
        lsr_pkg::REG_RESP3:   rd_nxt = resp_r[1][31:0];
        default:              rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r   <= M_IDLE;
      ctrl_r    <= '0;
      ist_r     <= '0;
      msk_r     <= '0;
      resp_r[0] <= '0;
      resp_r[1] <= '0;
      tx_r      <= '0;
      cnt_r     <= '0;
      last_r    <= '0;
      acc_r     <= '0;
      rx_r      <= '0;
      ph_r      <= 1'b0;
      tmo_r     <= '0;
      ack_r     <= 1'b0;
      rd_r      <= '0;
    end else begin
      state_r <= state_nxt;
      ctrl_r  <= ctrl_nxt;
      ist_r   <= ist_nxt;
      msk_r   <= msk_nxt;
      resp_r  <= resp_nxt;
      tx_r    <= tx_nxt;
      cnt_r   <= cnt_nxt;
      last_r  <= last_nxt;
      acc_r   <= acc_nxt;
      rx_r    <= rx_nxt;
      ph_r    <= ph_nxt;
      tmo_r   <= tmo_nxt;
      ack_r   <= ack_nxt;
      rd_r    <= rd_nxt;
    end
  end

  assign lnk.hdr_vld      = (state_r == M_PREP && cnt_r == 4'h0)
                          || state_r == M_RHDR;
  assign lnk.byte_vld     = state_r == M_PREP && cnt_r != 4'h0;
  assign lnk.m_byte       = tx_r[79:72];
  assign avs_readdata     = rd_r;
  assign avs_waitrequest  = avs_read && !ack_r;
  assign irq              = |(ist_r & msk_r);
endmodule : lsr_master

// ===== tb/lsr_link_props.sv
/* Concurrent checks on the link between master end and device end.
   Assumes one clock and srst synchronous, active high. */
`timescale 1ns/1ps
module lsr_link_props (
  input wire logic       sys_clk,
  input wire logic       srst,
  input wire logic       hdr_vld,
  input wire logic       byte_vld,
  input wire logic [7:0] m_byte,
  input wire logic       rsp_vld,
  input wire logic [7:0] rsp_byte
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ==========================================================
  // Response byte count and running checksum
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] acc_r, acc_nxt;
  logic [8:0] sum;
  logic       p8, p7, rd;
  always_comb begin
    sum     = {1'b0, acc_r} + {1'b0, rsp_byte};
    cnt_nxt = rsp_vld ? cnt_r + 4'h1 : 4'h0;
    acc_nxt = rsp_vld ? sum[7:0] + {7'h00, sum[8]} : 8'h00;
    p8      = hdr_vld && m_byte == 8'h3c;
    p7      = hdr_vld && !m_byte[5];
    rd      = hdr_vld && m_byte == 8'h7d;
  end
  always_ff @(posedge sys_clk) begin
    cnt_r <= srst ? 4'h0 : cnt_nxt;
    acc_r <= srst ? 8'h00 : acc_nxt;
  end
  strobe_excl_a: assert property (!(hdr_vld && byte_vld))
    else $error("header and data strobes together");
  prep_len_a: assert property (p8 |=> byte_vld[*8] ##1 byte_vld)
    else $error("long prepare is not nine bytes");
  prep_head_a: assert property (p8 |=> m_byte == 8'h80 ##1
    m_byte inside {8'h81, 8'h82} ##1 m_byte[7])
    else $error("bad long prepare head");
  prep_fill_a: assert property (p8 |-> ##4 (m_byte == 8'hff)[*5])
    else $error("bad long prepare fill");
  short_prep_a: assert property (p7 |=> (byte_vld && m_byte[7])[*2]
    ##1 byte_vld) else $error("bad short prepare");
  id_parity_a: assert property (hdr_vld |-> m_byte[7:6] ==
    {~(m_byte[1] ^ m_byte[3] ^ m_byte[4] ^ m_byte[5]),
     m_byte[0] ^ m_byte[1] ^ m_byte[2] ^ m_byte[4]})
    else $error("bad identifier parity");
  rsp_cause_a: assert property ($rose(rsp_vld) |-> $past(rd, 2))
    else $error("response without reading header");
  rsp_len_a: assert property ($rose(rsp_vld) |->
    rsp_vld[*8] ##1 rsp_vld ##1 !rsp_vld)
    else $error("response is not nine bytes");
  rsp_sum_a: assert property (rsp_vld && cnt_r == 4'h8 |->
    rsp_byte == ~acc_r) else $error("bad response checksum");
  cover property (p8);
  cover property (p7);
  cover property (rsp_vld && cnt_r == 4'h8);
endmodule : lsr_link_props

// ===== tb/tb_lin_status_otp_readback.sv
/* Testbench: master and device ends joined by the link, run over Avalon.
   Assumes the design files and the link checker are compiled first. */
`timescale 1ns/1ps
module tb_lin_status_otp_readback;
  typedef struct {
    logic [31:0] ctrl;
    logic [31:0] e[4];
    logic        two;
  } lsr_row_type;
  logic          sys_clk = 1'b0;
  logic          srst = 1'b1;
  logic [2:0]    avs_address = 3'h0;
  logic          avs_read = 1'b0;
  logic          avs_write = 1'b0;
  logic [31:0]   avs_writedata = 32'h0000_0000;
  logic [31:0]   avs_readdata, q;
  logic          avs_waitrequest, irq, flag_clear;
  logic [106:0]  sv = 107'h5a3_c96e_1b72_d4f0_8e35_a7c1_39bd;
  logic [63:0]   prom = 64'h1f2e_3d4c_5b6a_7988;
  logic [31:0]   fs[4], pm[4];
  lsr_row_type   rows[5];
  int            num_errors = 0;
  int            checks_done = 0;
  int            fc_cnt = 0;
  int            fc0;
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (flag_clear === 1'b1) fc_cnt <= fc_cnt + 1;
  lsr_link_if lsr_link_if_i ();
  lsr_master #(.TMO_CYC(32)) lsr_master_i (.sys_clk(sys_clk), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .lnk(lsr_link_if_i));
  lsr_device lsr_device_i (.sys_clk(sys_clk), .srst(srst),
    .lnk(lsr_link_if_i), .node_addr(7'h2a), .dyn_id(5'h05), .status(sv),
    .prom_data(prom), .flag_clear(flag_clear));
  lsr_link_props lsr_link_props_i (.sys_clk(sys_clk), .srst(srst),
    .hdr_vld(lsr_link_if_i.hdr_vld), .byte_vld(lsr_link_if_i.byte_vld),
    .m_byte(lsr_link_if_i.m_byte), .rsp_vld(lsr_link_if_i.rsp_vld),
    .rsp_byte(lsr_link_if_i.rsp_byte));
  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] seen, exp, input string nm);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic [2:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic run(input logic [31:0] c);
    bus(lsr_pkg::REG_CTRL, 1'b1, c);
    do bus(lsr_pkg::REG_CTRL, 1'b0, 32'h0); while (q[31] === 1'b1);
  endtask : run
  task automatic test_done;
    $display("Checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    test_done();
  end
  // ==========================================================
  // Sequence
  initial begin
    fs = '{{8'haa, sv[106:83]}, {sv[82:67], 4'hf, sv[66:55]},
           {8'haa, sv[54:31]},
           {sv[30:23], sv[19:12], sv[11:9], 1'b1, sv[8], sv[22:20], sv[7:0]}};
    pm = '{prom[63:32], prom[31:0], 32'h0, 32'h0};
    rows = '{'{32'h002a_0001, fs, 1'b1}, '{32'h002a_0201, fs, 1'b0},
             '{32'h002a_0002, pm, 1'b0}, '{32'h052a_0102, pm, 1'b0},
             '{32'h052a_0101, fs, 1'b1}};
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    chk({31'h0, flag_clear}, 32'h0, "flag clear in reset");
    bus(lsr_pkg::REG_IRQ_MSK, 1'b1, 32'h0000_0003);
    for (int i = 0; i < 5; i++) begin
      fc0 = fc_cnt;
      run(rows[i].ctrl);
      bus(lsr_pkg::REG_IRQ_ST, 1'b0, 32'h0);
      chk(q, 32'h0000_0001, "done status");
      chk({31'h0, irq}, 32'h1, "irq");
      for (int k = 0; k < 4; k++)
        if (k < 2 || rows[i].two) begin
          bus(3'(lsr_pkg::REG_RESP0 + k), 1'b0, 32'h0);
          chk(q, rows[i].e[k], "response word");
        end
      chk(32'(fc_cnt - fc0), {31'h0, rows[i].ctrl[0]}, "flag clear");
      bus(lsr_pkg::REG_IRQ_ST, 1'b1, 32'h0000_0003);
    end
    // Masked completion still latches; clearing drops the line
    bus(lsr_pkg::REG_IRQ_MSK, 1'b1, 32'h0);
    run(32'h002a_0002);
    bus(lsr_pkg::REG_IRQ_ST, 1'b0, 32'h0);
    chk(q, 32'h0000_0001, "masked status");
    chk({31'h0, irq}, 32'h0, "masked irq");
    bus(lsr_pkg::REG_IRQ_MSK, 1'b1, 32'h0000_0003);
    bus(lsr_pkg::REG_IRQ_ST, 1'b1, 32'h0000_0001);
    bus(lsr_pkg::REG_IRQ_ST, 1'b0, 32'h0);
    chk({31'h0, irq}, 32'h0, "cleared irq");
    // Foreign node address: device stays silent, master times out
    run(32'h0011_0001);
    bus(lsr_pkg::REG_IRQ_ST, 1'b0, 32'h0);
    chk(q, 32'h0000_0002, "foreign address");
    bus(lsr_pkg::REG_IRQ_ST, 1'b1, 32'h0000_0003);
    bus(lsr_pkg::REG_CTRL, 1'b1, 32'h002a_0003);
    bus(lsr_pkg::REG_CTRL, 1'b0, 32'h0);
    chk({31'h0, q[31]}, 32'h0, "unknown command");
    bus(3'h7, 1'b0, 32'h0);
    chk(q, 32'h0, "unmapped word");
    // Reset in mid-sequence returns both ends to idle
    bus(lsr_pkg::REG_CTRL, 1'b1, 32'h002a_0001);
    repeat (12) @(posedge sys_clk);
    srst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    chk({31'h0, irq}, 32'h0, "irq after reset");
    chk(avs_readdata, 32'h0, "readdata after reset");
    bus(lsr_pkg::REG_CTRL, 1'b0, 32'h0);
    chk(q, 32'h0, "control after reset");
    run(32'h002a_0002);
    bus(lsr_pkg::REG_RESP0, 1'b0, 32'h0);
    chk(q, pm[0], "memory after reset");
    test_done();
  end
endmodule : tb_lin_status_otp_readback
